// *** inc/scbg_defines.svh ***
// Timing and framing constants for the smart card serial and bit-rate block.
`ifndef SCBG_DEFINES_SVH
`define SCBG_DEFINES_SVH
`define SCBG_PRESC_MAX0 6'h00
`define SCBG_PRESC_MAX1 6'h03
`define SCBG_PRESC_MAX2 6'h0f
`define SCBG_PRESC_MAX3 6'h3f
`define SCBG_DIV_RESET 8'h00
`define SCBG_SUB_LAST 5'h1f
`define SCBG_SUB_MID 5'h10
`define SCBG_ETU_DATA0 4'h1
`define SCBG_ETU_PARITY 4'h9
`define SCBG_ETU_RELEASE 4'ha
`define SCBG_ETU_ERR_SAMPLE 4'hb
`define SCBG_ETU_GUARD_END 4'hc
`define SCBG_ETU_RETX 4'he
`define SCBG_FIFO_DEPTH 32
`define SCBG_DATA_W 8
`define SCBG_SYNC_QUARTERS 4
`endif

// *** inc/scbg_pkg.sv ***
// Types shared by the smart card serial and bit-rate block.
package scbg_pkg;
    typedef enum logic [2:0] {
        SCBG_IDLE = 3'b001,
        SCBG_TX = 3'b010,
        SCBG_RX = 3'b100
    } scbg_state_t;
endpackage

// *** src/scbg_top.sv ***
// Smart card serial channel with bit-rate generator and transmit FIFO.
`timescale 1ns/1ns
`include "scbg_defines.svh"

// Plain valid/ready FIFO; DEPTH must be a power of two so pointers wrap.
module scbg_fifo #(
    parameter int WIDTH = `SCBG_DATA_W,
    parameter int DEPTH = `SCBG_FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Full when pointers differ only in the wrap bit.
    assign in_ready = (wr_q != {~rd_q[AW], rd_q[AW-1:0]});
    assign out_valid = (wr_q != rd_q);
    assign out_data = mem_q[rd_q[AW-1:0]];

    // Pointer update.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
        end
    end

    // Storage carries no reset; only written slots are ever read.
    always_ff @(posedge core_clk) begin
        if (push) mem_q[wr_q[AW-1:0]] <= in_data;
    end
endmodule

// What this block does
// - Eight-bit divisor accepts any value 0 to 255.
// - Prescaler code selects clock, /4, /16, /64.
// - Sync rate equals clock over 8*2^(2n-1)*(N+1).
// - Code zero, divisor zero: no gapless streaming.
// - Smart card frames: eight data bits plus parity.
// - Generate transmit parity, check receive parity.
// - At least two etu guard after parity.
// - Parity error: drive low 1 etu at 10.5.
// - Card error seen at 11 etu: resend at 14 etu.
// - One etu is 32 base ticks, eight generated bit periods.
// - Direct and inverse convention selectable by software.
// - Three requests: tx empty, rx full, error.
// - Empty and full requests can start block transfers.
module scbg_top (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Configuration held steady by software, and the error clear pulse.
    input wire logic [1:0] presc_sel,
    input wire logic [7:0] bit_rate_divisor,
    input wire logic sync_mode,
    input wire logic smart_mode,
    input wire logic inverse_conv,
    input wire logic blk_xfer_tx_en,
    input wire logic blk_xfer_rx_en,
    input wire logic err_clear,
    // Transmit stream into the FIFO.
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    // Receive stream.
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    // Card line, open drain.
    input wire logic line_in,
    output logic line_out,
    output logic line_oe,
    // Synchronous clock and status.
    output logic sync_clk,
    output logic rate_limited,
    // Requests.
    output logic irq_tx_empty,
    output logic irq_rx_full,
    output logic irq_error,
    output logic blk_xfer_tx_req,
    output logic blk_xfer_rx_req
);
    // Terminal count of the prescaler for each code.
    function automatic logic [5:0] presc_max(input logic [1:0] sel);
        case (sel)
            2'h0: presc_max = `SCBG_PRESC_MAX0;
            2'h1: presc_max = `SCBG_PRESC_MAX1;
            2'h2: presc_max = `SCBG_PRESC_MAX2;
            default: presc_max = `SCBG_PRESC_MAX3;
        endcase
    endfunction

    // Bit order swap used by both directions of the inverse convention.
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev8[i] = v[7-i];
    endfunction

    logic [5:0] presc_q;
    logic [7:0] div_q;
    logic sync_half_q;
    logic sync_clk_q;
    logic rate_lim_q;
    scbg_pkg::scbg_state_t st_q;
    logic [4:0] sub_q;
    logic [3:0] etu_q;
    logic [7:0] tx_byte_q;
    logic err_seen_q;
    logic [8:0] rx_sh_q;
    logic par_bad_q;
    logic line_oe_q;
    logic err_q;
    logic rx_valid_q;
    logic [7:0] rx_data_q;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic tx_pop;

    // Prescaler then divisor: any divisor 0..255 gives a base tick.
    wire presc_tick = (presc_q >= presc_max(presc_sel));
    wire base_tick = presc_tick && (div_q >= bit_rate_divisor);
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            presc_q <= 6'h00;
            div_q <= `SCBG_DIV_RESET;
        end else begin
            presc_q <= presc_tick ? 6'h00 : presc_q + 6'h01;
            if (presc_tick) div_q <= base_tick ? `SCBG_DIV_RESET : div_q + 8'h01;
        end
    end

    // Sync clock: four base ticks per bit gives clock/(8*2^(2n-1)*(N+1)).
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sync_half_q <= 1'b0;
            sync_clk_q <= 1'b0;
        end else if (sync_mode && base_tick) begin
            sync_half_q <= ~sync_half_q;
            if (sync_half_q) sync_clk_q <= ~sync_clk_q;
        end
    end

    // At the fastest setting a bit lasts four clocks, too short to reload
    // between characters, so software is told that gaps will appear.
    always_ff @(posedge core_clk) begin
        if (!reset_n) rate_lim_q <= 1'b0;
        else rate_lim_q <= (presc_sel == 2'h0) && (bit_rate_divisor == 8'h00);
    end

    scbg_fifo #(.WIDTH(`SCBG_DATA_W), .DEPTH(`SCBG_FIFO_DEPTH)) u_txf (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .out_valid(fifo_valid),
        .out_ready(tx_pop),
        .out_data(fifo_data)
    );

    // Frame timing: 32 base ticks form one etu, the smart card bit period.
    wire sub_wrap = base_tick && (sub_q == `SCBG_SUB_LAST);
    wire at_etu = base_tick && (sub_q == 5'h00);
    wire at_mid = base_tick && (sub_q == `SCBG_SUB_MID);
    wire idle = (st_q == scbg_pkg::SCBG_IDLE);
    // Receive has priority: a start bit from the card must never be missed.
    wire rx_start = idle && smart_mode && !line_in;
    assign tx_pop = idle && smart_mode && line_in && fifo_valid;
    wire tx_err_hit = (st_q == scbg_pkg::SCBG_TX) && at_etu
        && (etu_q == `SCBG_ETU_ERR_SAMPLE) && !line_in;
    wire tx_done = (st_q == scbg_pkg::SCBG_TX) && at_etu && !err_seen_q
        && (etu_q == `SCBG_ETU_GUARD_END);
    wire tx_retx = (st_q == scbg_pkg::SCBG_TX) && at_etu && err_seen_q
        && (etu_q == `SCBG_ETU_RETX);
    wire rx_false = (st_q == scbg_pkg::SCBG_RX) && at_mid
        && (etu_q == 4'h0) && line_in;
    wire rx_check = (st_q == scbg_pkg::SCBG_RX) && at_etu
        && (etu_q == `SCBG_ETU_RELEASE);
    wire rx_end = (st_q == scbg_pkg::SCBG_RX) && at_etu
        && (etu_q == `SCBG_ETU_GUARD_END);

    // Received logical bit and byte in either convention.
    wire rx_bit = inverse_conv ? ~line_in : line_in;
    wire [7:0] rx_byte = inverse_conv ? rev8(rx_sh_q[7:0]) : rx_sh_q[7:0];
    wire rx_par_bad = ^{rx_byte, rx_sh_q[8]};
    wire rx_deliver = rx_check && !rx_par_bad;
    wire rx_overrun = rx_deliver && rx_valid_q && !rx_ready;

    // Transmit level for the current etu: start low, data, even parity.
    wire [3:0] bit_idx = etu_q - `SCBG_ETU_DATA0;
    wire [7:0] tx_ord = inverse_conv ? rev8(tx_byte_q) : tx_byte_q;
    wire tx_logic = (etu_q == `SCBG_ETU_PARITY) ? ^tx_byte_q : tx_ord[bit_idx[2:0]];
    wire tx_level = (etu_q == 4'h0) ? 1'b0 : (inverse_conv ? ~tx_logic : tx_logic);
    wire tx_drive = (st_q == scbg_pkg::SCBG_TX) && (etu_q < `SCBG_ETU_RELEASE) && !tx_level;
    // Error signal: from 10.5 etu to 11.5 etu after the start edge.
    wire rx_drive = (st_q == scbg_pkg::SCBG_RX) && par_bad_q
        && (((etu_q == `SCBG_ETU_RELEASE) && (sub_q >= `SCBG_SUB_MID))
        || ((etu_q == `SCBG_ETU_ERR_SAMPLE) && (sub_q < `SCBG_SUB_MID)));

    // Frame sequencer shared by both directions of the half-duplex line.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_q <= scbg_pkg::SCBG_IDLE;
        end else begin
            unique case (st_q)
                scbg_pkg::SCBG_IDLE: begin
                    if (rx_start) st_q <= scbg_pkg::SCBG_RX;
                    else if (tx_pop) st_q <= scbg_pkg::SCBG_TX;
                end
                scbg_pkg::SCBG_TX: begin
                    if (tx_done) st_q <= scbg_pkg::SCBG_IDLE;
                end
                scbg_pkg::SCBG_RX: begin
                    if (rx_end || rx_false) st_q <= scbg_pkg::SCBG_IDLE;
                end
                default: st_q <= scbg_pkg::SCBG_IDLE;
            endcase
        end
    end

    // Position inside the frame; restarts at each frame and resend.
    always_ff @(posedge core_clk) begin
        if (!reset_n || idle || tx_retx) begin
            sub_q <= 5'h00;
            etu_q <= 4'h0;
        end else if (base_tick) begin
            sub_q <= sub_q + 5'h01;
            if (sub_wrap) etu_q <= etu_q + 4'h1;
        end
    end

    // Transmit byte and card error memory.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            tx_byte_q <= 8'h00;
            err_seen_q <= 1'b0;
        end else begin
            if (tx_pop && !rx_start) tx_byte_q <= fifo_data;
            if (idle || tx_retx) err_seen_q <= 1'b0;
            else if (tx_err_hit) err_seen_q <= 1'b1;
        end
    end

    // Receive shift: eight data bits then parity, sampled mid-bit.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rx_sh_q <= 9'h000;
            par_bad_q <= 1'b0;
        end else begin
            if (st_q == scbg_pkg::SCBG_RX && at_mid && etu_q != 4'h0
                    && etu_q <= `SCBG_ETU_PARITY) begin
                rx_sh_q <= {rx_bit, rx_sh_q[8:1]};
            end
            if (idle) par_bad_q <= 1'b0;
            else if (rx_check) par_bad_q <= rx_par_bad;
        end
    end

    // Receive holding register; a byte not yet taken is kept, not lost.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rx_valid_q <= 1'b0;
            rx_data_q <= 8'h00;
        end else if (rx_deliver && !rx_overrun) begin
            rx_valid_q <= 1'b1;
            rx_data_q <= rx_byte;
        end else if (rx_ready) begin
            rx_valid_q <= 1'b0;
        end
    end

    // Line driver and sticky error; a new error beats a clear.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            line_oe_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            line_oe_q <= tx_drive || rx_drive;
            if (tx_err_hit || (rx_check && rx_par_bad) || rx_overrun) err_q <= 1'b1;
            else if (err_clear) err_q <= 1'b0;
        end
    end

    // Outputs; requests are levels that follow the block's own state.
    assign line_out = 1'b0;
    assign line_oe = line_oe_q;
    assign rx_valid = rx_valid_q;
    assign rx_data = rx_data_q;
    assign sync_clk = sync_clk_q;
    assign rate_limited = rate_lim_q;
    assign irq_tx_empty = smart_mode && !fifo_valid;
    assign irq_rx_full = rx_valid_q;
    assign irq_error = err_q;
    assign blk_xfer_tx_req = blk_xfer_tx_en && irq_tx_empty && tx_ready;
    assign blk_xfer_rx_req = blk_xfer_rx_en && irq_rx_full;

    // Helper: clocks between sync clock rises with configuration held.
    logic [17:0] per_q;
    logic held_q;
    logic [1:0] cfg_presc_q;
    logic [7:0] cfg_div_q;
    // Last cycle's setting timed the rise, so a change just before it is not blamed.
    wire [17:0] per_exp = 18'(`SCBG_SYNC_QUARTERS * (presc_max(cfg_presc_q) + 1)
        * (cfg_div_q + 1));
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            per_q <= 18'h00001;
            held_q <= 1'b0;
            cfg_presc_q <= 2'h0;
            cfg_div_q <= 8'h00;
        end else begin
            cfg_presc_q <= presc_sel;
            cfg_div_q <= bit_rate_divisor;
            per_q <= (sync_clk_q && !$past(sync_clk_q)) ? 18'h00001 : per_q + 18'h00001;
            if (!$stable(presc_sel) || !$stable(bit_rate_divisor) || !sync_mode) held_q <= 1'b0;
            else if (sync_clk_q && !$past(sync_clk_q)) held_q <= 1'b1;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_sync_period: assert property (
        $rose(sync_clk_q) && held_q |-> per_q == per_exp)
        else $error("sync clock period does not match prescaler and divisor");
    a_presc_four: assert property (
        presc_tick && presc_sel == 2'h1 && $stable(presc_sel) ##1 presc_sel == 2'h1 [*4]
        |-> presc_tick && !$past(presc_tick) && !$past(presc_tick, 2)
        && !$past(presc_tick, 3))
        else $error("divide by four prescaler spacing wrong");
    a_rate_flag: assert property (
        presc_sel == 2'h0 && bit_rate_divisor == 8'h00 |=> rate_limited)
        else $error("fastest setting not flagged");
    a_tx_guard_idle: assert property (
        st_q == scbg_pkg::SCBG_TX && etu_q >= `SCBG_ETU_RELEASE && etu_q != 4'h0
        |=> !line_oe_q || $past(tx_retx))
        else $error("line driven during guard time");
    a_start_low: assert property (
        st_q == scbg_pkg::SCBG_TX && etu_q == 4'h0 && sub_q == 5'h05 |=> line_oe_q)
        else $error("start bit not driven low");
    a_err_window: assert property (
        $rose(line_oe_q) && st_q == scbg_pkg::SCBG_RX
        |-> par_bad_q && etu_q == `SCBG_ETU_RELEASE)
        else $error("error signal outside its window");
    a_retx_cause: assert property (
        st_q == scbg_pkg::SCBG_TX && etu_q > `SCBG_ETU_GUARD_END |-> err_seen_q)
        else $error("frame held past guard without card error");
    a_err_sticky: assert property (
        tx_err_hit || (rx_check && rx_par_bad) |=> irq_error)
        else $error("error request not raised");
    a_rx_parity: assert property (
        rx_check && rx_par_bad |=> !$rose(rx_valid_q))
        else $error("bad parity byte delivered");

    c_tx_frame: cover property (tx_done);
    c_tx_resend: cover property (tx_retx);
    c_rx_error: cover property ($rose(line_oe_q) && st_q == scbg_pkg::SCBG_RX);
    c_rx_good: cover property (rx_deliver && inverse_conv);
endmodule

// *** tb/scbg_card_model.sv ***
// Behavioural card on the open-drain line, which has a pull-up.
`timescale 1ns/1ns
module scbg_card_model #(
    parameter int ETU = 32
) (
    // Clock, line and convention.
    input wire logic core_clk,
    input wire logic line,
    input wire logic inverse_conv,
    // Card pull-down.
    output logic pull_low
);
    logic [7:0] got_q[$];
    int gap_q[$];
    int nack_cnt = 0;
    bit sending = 0;
    bit err_seen = 0;
    int now = 0;
    int last = 0;
    initial pull_low = 0;
    always @(posedge core_clk) now <= now + 1;
    task automatic wt(int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    // Sampling is mid-bit, so a late start edge of a clock or two is tolerated.
    initial begin
        logic [8:0] f;
        logic [7:0] d;
        forever begin
            wt(1);
            if (line === 1'b0 && !sending) begin
                gap_q.push_back(now - last);
                last = now;
                wt(ETU / 2);
                for (int i = 0; i < 9; i++) begin
                    wt(ETU);
                    f[i] = line ^ inverse_conv;
                end
                for (int i = 0; i < 8; i++) d[i] = inverse_conv ? f[7 - i] : f[i];
                wt(ETU);
                // The pull-down is drawn when a scenario asks for it or the received parity is wrong.
                if (nack_cnt > 0 || ^f) begin
                    if (nack_cnt > 0) nack_cnt--;
                    pull_low = 1;
                    wt(ETU);
                    pull_low = 0;
                end else begin
                    got_q.push_back(d);
                end
            end
        end
    end
    // Send one character; bad flips the parity to draw an error signal.
    task automatic send(logic [7:0] d, bit bad);
        logic [8:0] f;
        sending = 1;
        for (int i = 0; i < 8; i++) f[i] = inverse_conv ? d[7 - i] : d[i];
        f[8] = ^d ^ bad;
        pull_low = 1;
        wt(ETU);
        for (int i = 0; i < 9; i++) begin
            pull_low = !(f[i] ^ inverse_conv);
            wt(ETU);
        end
        pull_low = 0;
        wt(ETU * 3 / 4);
        err_seen = !line;
        wt(ETU * 5 / 4);
        sending = 0;
    endtask
endmodule

// *** tb/test_smart_card_serial_baud_gen.sv ***
// Self-checking bench for the smart card serial and bit-rate block.
`timescale 1ns/1ns
module test_smart_card_serial_baud_gen;
    localparam int ETU = 32;
    logic core_clk, reset_n, sync_mode, smart_mode, inverse_conv, err_clear;
    logic blk_xfer_tx_en, blk_xfer_rx_en, tx_valid, tx_ready, rx_valid, rx_ready;
    logic [1:0] presc_sel;
    logic [7:0] bit_rate_divisor, tx_data, rx_data, d;
    logic line_out, line_oe, sync_clk, rate_limited, card_low;
    logic irq_tx_empty, irq_rx_full, irq_error, blk_xfer_tx_req, blk_xfer_rx_req;
    logic [31:0] seed = 32'he9f1e6d0;
    logic [7:0] exp_q[$];
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    int c;
    wire line_w = !(line_oe && !line_out) && !card_low;
    scbg_top uut (.core_clk(core_clk), .reset_n(reset_n), .presc_sel(presc_sel),
        .bit_rate_divisor(bit_rate_divisor), .sync_mode(sync_mode),
        .smart_mode(smart_mode), .inverse_conv(inverse_conv),
        .blk_xfer_tx_en(blk_xfer_tx_en), .blk_xfer_rx_en(blk_xfer_rx_en),
        .err_clear(err_clear), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .line_in(line_w), .line_out(line_out), .line_oe(line_oe), .sync_clk(sync_clk),
        .rate_limited(rate_limited), .irq_tx_empty(irq_tx_empty),
        .irq_rx_full(irq_rx_full), .irq_error(irq_error),
        .blk_xfer_tx_req(blk_xfer_tx_req), .blk_xfer_rx_req(blk_xfer_rx_req));
    scbg_card_model #(.ETU(ETU)) card (.core_clk(core_clk), .line(line_w),
        .inverse_conv(inverse_conv), .pull_low(card_low));
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    // Half period of the bit clock: clock over 8*2^(2n-1)*(N+1), halved.
    function automatic int exp_half(int n, int dv);
        return 2 * (1 << (2 * n)) * (dv + 1);
    endfunction
    task automatic tick();
        @(posedge core_clk);
        #2;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic chk_min(string nm, int e, int g);
        check_count++;
        if (g < e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected at least %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic toggle_gap();
        logic s;
        s = sync_clk;
        c = 0;
        while (sync_clk === s && c < 20000) begin
            tick();
            c++;
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        core_clk = 0;
        forever #10 core_clk = ~core_clk;
    end
    // A hang counts as a mismatch and closes the run.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        {reset_n, presc_sel, bit_rate_divisor, sync_mode, smart_mode} = '0;
        {inverse_conv, err_clear, tx_valid, tx_data, rx_ready} = '0;
        {blk_xfer_tx_en, blk_xfer_rx_en} = 2'h3;
        repeat (12) @(posedge core_clk);
        #2 reset_n = 1;
        tick();
        chk("tx_ready", 1'h1, tx_ready);
        chk("idle_flags", 5'h00, {rx_valid, line_oe, line_out, irq_error, sync_clk});
        // Bit clock for every prescaler code, plus divisor corners.
        sync_mode = 1;
        for (int k = 0; k < 6; k++) begin
            presc_sel = k < 4 ? k[1:0] : 2'h0;
            bit_rate_divisor = k == 4 ? 8'hff : (k == 5 ? 8'h00 : rnd() & 8'h07);
            repeat (3) toggle_gap();
            chk("sync_half", exp_half(presc_sel, bit_rate_divisor), c);
            chk("rate_limited", presc_sel == 2'h0 && bit_rate_divisor == 8'h00,
                rate_limited);
        end
        // Fill the FIFO while stalled, then drain it onto the card.
        for (int cv = 0; cv < 2; cv++) begin
            inverse_conv = cv[0];
            smart_mode = 0;
            card.got_q.delete();
            card.gap_q.delete();
            exp_q.delete();
            for (int i = 0; i < 33; i++) begin
                tx_data = i == 0 ? 8'h00 : (i == 1 ? 8'hff : rnd());
                tx_valid = 1;
                if (tx_ready === 1'b1) exp_q.push_back(tx_data);
                tick();
            end
            tx_valid = 0;
            chk("fifo_words", 32, exp_q.size());
            chk("tx_ready_full", 1'h0, tx_ready);
            smart_mode = 1;
            c = 0;
            while (card.got_q.size() < 32 && c < 20000) begin
                tick();
                c++;
            end
            for (int i = 0; i < 32; i++) chk("tx_byte", exp_q[i], card.got_q[i]);
            for (int i = 1; i < 32; i++) chk_min("tx_gap", 12 * ETU, card.gap_q[i]);
            d = rnd();
            blk_xfer_tx_en = d[0];
            tick();
            chk("tx_empty", 2'h2 | blk_xfer_tx_en, {irq_tx_empty, blk_xfer_tx_req});
        end
        // Card flags the first copy; the same byte must come again.
        card.gap_q.delete();
        card.nack_cnt = 1;
        tx_data = rnd();
        tx_valid = 1;
        tick();
        tx_valid = 0;
        c = 0;
        while (card.got_q.size() < 33 && c < 2000) begin
            tick();
            c++;
        end
        chk("resent_byte", tx_data, card.got_q[32]);
        chk_min("resend_gap", 27 * ETU / 2, card.gap_q[1]);
        chk("err_tx", 1'h1, irq_error);
        err_clear = 1;
        tick();
        err_clear = 0;
        tick();
        chk("err_clear", 1'h0, irq_error);
        // The last frame is still in its guard time; a card start now would collide.
        repeat (2 * ETU) tick();
        // Card sends good and bad parity in both conventions.
        for (int k = 0; k < 4; k++) begin
            inverse_conv = k[0];
            d = rnd();
            blk_xfer_rx_en = d[0];
            d = rnd();
            card.send(d, k[1]);
            chk("err_signal", k[1], card.err_seen);
            chk("err_rx", k[1], irq_error);
            chk("rx_full", k[1] ? 3'h0 : (3'h6 | blk_xfer_rx_en),
                {rx_valid, irq_rx_full, blk_xfer_rx_req});
            if (!k[1]) chk("rx_byte", d, rx_data);
            rx_ready = 1;
            err_clear = 1;
            tick();
            {rx_ready, err_clear} = 2'h0;
            tick();
            chk("rx_taken", 1'h0, rx_valid);
        end
        give_verdict();
    end
endmodule
